// [bench/erp_core_assertions.sv]
// Assertions on the bus, run state and output ports of erp_core.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
module erp_core_assertions
  import erp_pkg::*;
(
  input wire logic mclk_i, // Clock.
  input wire logic resetn_i, // Reset, active low.
  input wire logic [7:0] avs_address_i, // Address.
  input wire logic avs_read_i, // Read.
  input wire logic avs_write_i, // Write.
  input wire logic [31:0] avs_writedata_i, // Write data.
  input wire logic avs_waitrequest_o, // Wait request.
  input wire logic [31:0] avs_readdata_o, // Read data.
  input wire logic ctrl_tick_i, // Period tick.
  input wire logic [NUM_CH*LVL_W-1:0] mv_o, // Output MV.
  input wire logic [NUM_CH-1:0] run_o // Run state.
);
  logic cmd_done;

  // A command write completes in this cycle.
  assign cmd_done = avs_write_i && !avs_waitrequest_o
                    && avs_address_i == ADDR_CMD;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  // Bus answers come one cycle after a request and last one cycle.
  chk_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("No answer one cycle after a request.");
  chk_wait_pulse: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Wait request low for more than one cycle.");
  chk_idle_wait: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("Answer without a request.");
  chk_rdata_hold: assert property (
    $changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("Read data moved without a read.");
  chk_cmd_reads: assert property (
    avs_read_i && !avs_waitrequest_o && avs_address_i == ADDR_CMD
    |-> avs_readdata_o == 32'h00000000)
    else $error("Command register read back nonzero.");
  // Outputs and run state move only at a period tick or a command.
  chk_mv_tick: assert property (
    $changed(mv_o) |-> $past(ctrl_tick_i) || $past(ctrl_tick_i, 2))
    else $error("Output MV moved without a tick.");
  chk_run_rise: assert property (
    (run_o & ~$past(run_o)) != 0 |-> $past(cmd_done && avs_writedata_i[0]))
    else $error("Channel started without a run command.");
  chk_run_fall: assert property (
    (~run_o & $past(run_o)) != 0
    |-> $past(ctrl_tick_i) || $past(ctrl_tick_i, 2) || $past(cmd_done))
    else $error("Channel stopped without a tick or command.");
  chk_srst_stop: assert property (
    cmd_done && avs_writedata_i[CMD_SRST] |=> run_o == 8'h00)
    else $error("Soft reset left a channel running.");
  // Main scenarios.
  cover property (cmd_done && avs_writedata_i[CMD_RUN]);
  cover property (ctrl_tick_i ##1 (~run_o & $past(run_o)) != 0);
  cover property (avs_write_i && !avs_waitrequest_o
                  && avs_address_i == ADDR_POL_PEND && run_o != 0);
endmodule

bind erp_core erp_core_assertions i_chk (
  .mclk_i(mclk_i),
  .resetn_i(resetn_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .avs_readdata_o(avs_readdata_o),
  .ctrl_tick_i(ctrl_tick_i),
  .mv_o(mv_o),
  .run_o(run_o)
);

// [bench/erp_core_tb.sv]
// Bench for erp_core: a reference model checks outputs and registers.
// Assumes erp_far_model drives the fault pins from the bench requests.
`timescale 1ns/1ps
module erp_core_tb;
  import erp_pkg::*;
  logic mclk_i, resetn_i, rd, wr, tick, wreq, irq;
  logic [7:0] run, mrun, lat, stp, frc, e;
  logic [7:0] adr;
  logic [31:0] wd, rdat, q;
  logic [63:0] mvc, mv;
  logic [SY_W-1:0] fq, pins;
  logic [5:0] pend, act;
  logic [1:0] mode;
  logic [7:0] lvl [8];
  int n_errors, check_count, seed;

  // Free-running 100 MHz clock.
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end

  erp_far_model i_far (.mclk_i(mclk_i), .req_i(fq), .pins_o(pins));
  erp_core i_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .ctrl_tick_i(tick), .mv_calc_i(mvc),
    .link_err_i(pins[SY_LINK]), .input_err_i(pins[SY_IN +: 8]),
    .pc_comm_err_i(pins[SY_PCC +: 2]), .zc_err_i(pins[SY_ZC +: 2]),
    .heater_oc_i(pins[SY_OC +: 8]), .heater_break_alarm_i(pins[SY_HB +: 8]),
    .relay_fault_alarm_i(pins[SY_RF +: 8]), .mv_o(mv), .run_o(run),
    .irq_o(irq)
  );

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  // One bus cycle, held until wait request is seen low; q takes the data.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    {rd, wr, adr, wd} <= {!w, w, a, d};
    for (i = 0; i < 20 && wreq !== 1'b0; i++) @(posedge mclk_i);
    q = rdat;
    {rd, wr} <= 2'h0;
    if (i == 20) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    bus(0, a, 0);
    cmp(q, x);
  endtask

  // In gradient mode a channel set grows to whole groups.
  function automatic logic [7:0] spread(input logic [7:0] v);
    logic [7:0] o;
    o = v;
    for (int c = 0; c < NUM_CH; c++)
      if (mode[MODE_GRAD] && v[c/GRP_SIZE*GRP_SIZE +: GRP_SIZE] != 0)
        o[c] = 1'b1;
    return o;
  endfunction

  // Reference model of stop and force decisions for every channel.
  task automatic calc;
    logic [7:0] iv, hv;
    logic le;
    le = fq[SY_LINK] & mode[MODE_DIRECT];
    for (int c = 0; c < NUM_CH; c++) begin
      iv[c] = fq[SY_IN+c] | fq[SY_PCC+c/PC_CH] | fq[SY_ZC+c/PC_CH];
      hv[c] = fq[SY_OC+c] | fq[SY_HB+c] | fq[SY_RF+c] | lat[c];
    end
    stp = (act[3:2] == 2 ? spread(iv) : 8'h00)
          | (act[5:4] == 2 ? spread(hv) : 8'h00) | {8{act[1:0] == 2 && le}};
    frc = act[3:2] == 0 ? fq[SY_IN +: 8] : 8'h00;
    frc = frc | (act[3:2] == 1 ? spread(iv) : 8'h00)
          | (act[5:4] == 1 ? spread(hv) : 8'h00) | {8{act[1:0] == 1 && le}};
  endtask

  // One control period with fresh computed MV, then compare outputs.
  task automatic do_tick;
    repeat (8) @(posedge mclk_i);
    {tick, mvc} <= {1'b1, $random(seed), $random(seed)};
    @(posedge mclk_i);
    tick <= 0;
    calc();
    if (act[5:4] == 2)
      lat = lat | fq[SY_OC +: 8] | fq[SY_HB +: 8] | fq[SY_RF +: 8];
    mrun = mrun & ~stp;
    repeat (3) @(posedge mclk_i);
    for (int c = 0; c < NUM_CH; c++) begin
      e = !mrun[c] ? 8'h00 : frc[c] ? lvl[c] : mvc[c*8 +: 8];
      cmp({24'h0, mv[c*8 +: 8]}, {24'h0, e});
    end
    cmp({24'h0, run}, {24'h0, mrun});
  endtask

  // Commands apply stop, fault clear, run, then soft reset.
  task automatic cmd(input logic [3:0] v);
    bus(1, ADDR_CMD, {28'h0, v});
    if (v[CMD_STOP]) mrun = 0;
    if (v[CMD_FCLR]) lat = 0;
    calc();
    if (v[CMD_RUN]) mrun = mrun | ~stp;
    if (v[CMD_SRST]) {act, mrun, lat} = {pend, 16'h0000};
  endtask

  task automatic pol(input logic [5:0] p);
    bus(1, ADDR_POL_PEND, {26'h0, p});
    if (mrun == 0) pend = p;
  endtask

  // Main sequence.
  initial begin
    seed = 32'h732c54ea;
    {resetn_i, rd, wr, tick, adr, wd, mvc, fq} = '0;
    {n_errors, check_count} = '0;
    {pend, act, mode, mrun, lat} = {12'h000, MODE_RST, 16'h0000};
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1;
    rdc(ADDR_POL_PEND, 0);
    rdc(ADDR_POL_ACT, 0);
    rdc(ADDR_MODE, {30'h0, MODE_RST});
    rdc(ADDR_CMD, 0);
    rdc(8'h30, 0);
    for (int c = 0; c < NUM_CH; c++) lvl[c] = 8'($random(seed));
    bus(1, ADDR_LVL_LO, {lvl[3], lvl[2], lvl[1], lvl[0]});
    bus(1, ADDR_LVL_HI, {lvl[7], lvl[6], lvl[5], lvl[4]});
    mode = 2'h2;
    bus(1, ADDR_MODE, 32'h2);
    pol(6'h25);
    rdc(ADDR_POL_ACT, 0);
    cmd(4'h4);
    rdc(ADDR_POL_ACT, 32'h25);
    cmd(4'h1);
    do_tick();
    pol(6'h00);
    rdc(ADDR_POL_PEND, 32'h25);
    bus(0, ADDR_IRQ_ST, 0);
    cmp({31'h0, q[IRQ_REJ]}, 32'h1);
    cmp({31'h0, irq}, 32'h0);
    bus(1, ADDR_IRQ_MSK, 32'h10);
    repeat (3) @(posedge mclk_i);
    cmp({31'h0, irq}, 32'h1);
    bus(1, ADDR_IRQ_ST, 32'h10);
    repeat (3) @(posedge mclk_i);
    cmp({31'h0, irq}, 32'h0);
    @(posedge mclk_i) fq[SY_IN +: 8] <= 8'h04;
    do_tick();
    rdc(ADDR_ERR, 32'h4);
    @(posedge mclk_i) {fq[SY_IN +: 8], fq[SY_LINK]} <= 9'h001;
    do_tick();
    mode = 2'h0;
    bus(1, ADDR_MODE, 32'h0);
    do_tick();
    @(posedge mclk_i) {fq[SY_LINK], fq[SY_HB +: 8]} <= 9'h020;
    do_tick();
    @(posedge mclk_i) fq[SY_HB +: 8] <= 8'h00;
    do_tick();
    cmd(4'h1);
    do_tick();
    cmd(4'h9);
    do_tick();
    cmd(4'h2);
    mode = 2'h1;
    bus(1, ADDR_MODE, 32'h1);
    pol(6'h08);
    cmd(4'h4);
    cmd(4'h1);
    @(posedge mclk_i) fq[SY_IN +: 8] <= 8'h40;
    do_tick();
    @(posedge mclk_i) fq[SY_IN +: 8] <= 8'h00;
    do_tick();
    cmd(4'h1);
    do_tick();
    @(posedge mclk_i) {fq[SY_ZC +: 2], fq[SY_PCC +: 2]} <= 4'h6;
    do_tick();
    cmd(4'h2);
    pol(6'h00);
    cmd(4'h4);
    @(posedge mclk_i) fq <= '0;
    cmd(4'h1);
    @(posedge mclk_i) {fq[SY_IN +: 8], fq[SY_HB +: 8]} <= 16'h0208;
    do_tick();
    rdc(ADDR_ALM_BASE + 8'h0C, 32'h800);
    cmd(4'h2);
    mode = 2'h3;
    bus(1, ADDR_MODE, 32'h3);
    pol(6'h16);
    cmd(4'h4);
    cmd(4'h1);
    @(posedge mclk_i) {fq[SY_IN +: 8], fq[SY_HB +: 8]} <= 16'h0010;
    do_tick();
    @(posedge mclk_i) fq[SY_LINK] <= 1'b1;
    do_tick();
    tally_and_finish();
  end
endmodule

// [bench/erp_far_model.sv]
// Far-side model: host link controller and two power controller units.
// Assumes the bench asks for faults on mclk_i in the SY_* pin layout.
`timescale 1ns/1ps
module erp_far_model (
  input wire logic [36:0] req_i, // Faults asked for by the bench.
  input wire logic mclk_i, // Clock.
  output logic [36:0] pins_o // Fault pin levels.
);
  // Pins move just after an edge; a power controller flags its unit.
  always_ff @(posedge mclk_i) begin
    pins_o <= req_i;
  end
endmodule

// [core/erp_core.sv]
// Error response policy block: per-period fault handling of all channels.
// Assumes ctrl_tick_i and mv_calc_i come from logic on mclk_i and the
// fault pins are asynchronous.
`timescale 1ns/1ps
module erp_core (
  input wire logic mclk_i, // System clock, 100 MHz.
  input wire logic resetn_i, // Synchronous reset, active low.
  input wire logic [7:0] avs_address_i, // Byte address.
  input wire logic avs_read_i, // Read request.
  input wire logic avs_write_i, // Write request.
  input wire logic [31:0] avs_writedata_i, // Write data.
  input wire logic [3:0] avs_byteenable_i, // Byte enables.
  output logic [31:0] avs_readdata_o, // Read data.
  output logic avs_waitrequest_o, // Wait request.
  input wire logic ctrl_tick_i, // One pulse per control period.
  input wire logic [erp_pkg::NUM_CH*erp_pkg::LVL_W-1:0] mv_calc_i, // MV.
  input wire logic link_err_i, // Host link error pin.
  input wire logic [erp_pkg::NUM_CH-1:0] input_err_i, // Input errors.
  input wire logic [erp_pkg::NUM_PC-1:0] pc_comm_err_i, // Comms errors.
  input wire logic [erp_pkg::NUM_PC-1:0] zc_err_i, // Zero-cross faults.
  input wire logic [erp_pkg::NUM_CH-1:0] heater_oc_i, // Overcurrent.
  input wire logic [erp_pkg::NUM_CH-1:0] heater_break_alarm_i, // Break.
  input wire logic [erp_pkg::NUM_CH-1:0] relay_fault_alarm_i, // Relay.
  output logic [erp_pkg::NUM_CH*erp_pkg::LVL_W-1:0] mv_o, // Output MV.
  output logic [erp_pkg::NUM_CH-1:0] run_o, // Channel in control.
  output logic irq_o // Level interrupt.
);
  import erp_pkg::*;

  typedef struct packed {
    logic [NUM_CH*LVL_W-1:0] lvl;
    logic [NUM_CH*LVL_W-1:0] mv;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] hlatch;
    logic [POL_W-1:0] pol_pend;
    logic [POL_W-1:0] pol_act;
    logic [1:0] mode;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;
    logic irq;
    logic waitreq;
    logic [31:0] rdata;
  } erp_state_t;

  erp_state_t st_r;
  erp_state_t st_nxt;
  logic [SY_W-1:0] sy;

  // Spreads any set bit of a group onto all channels of that group.
  function automatic logic [NUM_CH-1:0] grp_spread(
    input logic [NUM_CH-1:0] v,
    input logic grad
  );
    logic [NUM_CH-1:0] o;
    o = v;
    if (grad) begin
      for (int g = 0; g < NUM_GRP; g++) begin
        if (|v[g*GRP_SIZE +: GRP_SIZE]) begin
          o[g*GRP_SIZE +: GRP_SIZE] = '1;
        end
      end
    end
    return o;
  endfunction

  // Maps one bit per power controller onto its channels.
  function automatic logic [NUM_CH-1:0] pc_spread(
    input logic [NUM_PC-1:0] v
  );
    logic [NUM_CH-1:0] o;
    o = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      o[c] = v[c / PC_CH];
    end
    return o;
  endfunction

  // Merges write data into a register under the byte enables.
  function automatic logic [31:0] be_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] o;
    o = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        o[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return o;
  endfunction

  // Picks one selector field out of a policy register.
  function automatic erp_pol_t pol_field(
    input logic [POL_W-1:0] p,
    input int lsb
  );
    return erp_pol_t'(p[lsb +: 2]);
  endfunction

  // Collects the channels that a stopping fault takes out of control.
  function automatic logic [NUM_CH-1:0] stop_mask(
    input logic [NUM_CH-1:0] in_v,
    input logic [NUM_CH-1:0] ht_v,
    input logic grad,
    input logic link_stop,
    input logic in_stop,
    input logic ht_stop
  );
    logic [NUM_CH-1:0] o;
    o = '0;
    if (in_stop) begin
      o = o | grp_spread(in_v, grad);
    end
    if (ht_stop) begin
      o = o | grp_spread(ht_v, grad);
    end
    if (link_stop) begin
      o = '1;
    end
    return o;
  endfunction

  // Fault pins pass the three-stage synchroniser.
  erp_sync3 #(
    .W(SY_W)
  ) u_sync (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .async_i({relay_fault_alarm_i, heater_break_alarm_i, heater_oc_i,
              zc_err_i, pc_comm_err_i, input_err_i, link_err_i}),
    .sync_o(sy)
  );

  // Policy evaluation, command handling and register access.
  always_comb begin
    logic grad;
    logic link_hit;
    logic [NUM_CH-1:0] in_raw;
    logic [NUM_CH-1:0] in_cls;
    logic [NUM_CH-1:0] ht_raw;
    logic [NUM_CH-1:0] ht_cls;
    logic [NUM_CH-1:0] stop_req;
    logic [NUM_CH-1:0] stop_fc;
    logic [NUM_CH-1:0] force_req;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    logic [31:0] wm;
    logic [31:0] mg;
    logic [31:0] rd;
    logic [2:0] ai;
    erp_pol_t pl;
    erp_pol_t pi;
    erp_pol_t ph;
    grad = 1'b0;
    link_hit = 1'b0;
    in_raw = '0;
    in_cls = '0;
    ht_raw = '0;
    ht_cls = '0;
    stop_req = '0;
    stop_fc = '0;
    force_req = '0;
    ev = '0;
    w1c = '0;
    wm = '0;
    mg = '0;
    rd = '0;
    ai = '0;
    st_nxt = st_r;

    // Only the selection adopted at the last reset governs.
    pl = pol_field(st_r.pol_act, POL_LINK_LSB);
    pi = pol_field(st_r.pol_act, POL_IN_LSB);
    ph = pol_field(st_r.pol_act, POL_HT_LSB);
    grad = st_r.mode[MODE_GRAD];

    // Link errors count only in direct link mode.
    link_hit = sy[SY_LINK] & st_r.mode[MODE_DIRECT];
    // Input class: channel inputs plus power controller faults.
    in_raw = sy[SY_IN +: NUM_CH];
    in_cls = in_raw | pc_spread(sy[SY_ZC +: NUM_PC])
           | pc_spread(sy[SY_PCC +: NUM_PC]);
    // Heater class; a stopped heater fault stays latched.
    ht_raw = sy[SY_OC +: NUM_CH] | sy[SY_HB +: NUM_CH]
           | sy[SY_RF +: NUM_CH];
    ht_cls = ht_raw | st_r.hlatch;

    // Stop targets: groups in gradient mode, else channels.
    stop_req = stop_mask(in_cls, ht_cls, grad,
      pl == POL_STOP && link_hit, pi == POL_STOP, ph == POL_STOP);
    // A fault clear in the same write frees the latched heater faults.
    stop_fc = stop_mask(in_cls, ht_raw, grad,
      pl == POL_STOP && link_hit, pi == POL_STOP, ph == POL_STOP);

    // Forced error level targets.
    if (pi == POL_FORCE) begin
      force_req = force_req | grp_spread(in_cls, grad);
    end else if (pi == POL_NOTIFY) begin
      force_req = force_req | in_raw;
    end
    if (ph == POL_FORCE) begin
      force_req = force_req | grp_spread(ht_cls, grad);
    end
    if (pl == POL_FORCE && link_hit) begin
      force_req = '1;
    end

    // Once per control period: stop targets and refresh outputs.
    if (ctrl_tick_i) begin
      st_nxt.run = st_r.run & ~stop_req;
      for (int c = 0; c < NUM_CH; c++) begin
        if (!st_nxt.run[c]) begin
          st_nxt.mv[c*LVL_W +: LVL_W] = '0;
        end else if (force_req[c]) begin
          st_nxt.mv[c*LVL_W +: LVL_W] =
            st_r.lvl[c*LVL_W +: LVL_W];
        end else begin
          st_nxt.mv[c*LVL_W +: LVL_W] =
            mv_calc_i[c*LVL_W +: LVL_W];
        end
      end
      if (ph == POL_STOP) begin
        st_nxt.hlatch = st_r.hlatch | ht_raw;
      end
      ev[IRQ_LINK] = link_hit;
      ev[IRQ_INPUT] = |in_cls;
      ev[IRQ_HEATER] = |ht_cls;
      ev[IRQ_STOP] = |(st_r.run & stop_req);
    end

    // Bus handshake: one wait cycle, then the access completes.
    st_nxt.waitreq = 1'b1;
    if ((avs_read_i || avs_write_i) && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      ai = avs_address_i[4:2];
      case (avs_address_i)
        ADDR_POL_PEND: rd[POL_W-1:0] = st_r.pol_pend;
        ADDR_POL_ACT: rd[POL_W-1:0] = st_r.pol_act;
        ADDR_MODE: rd[1:0] = st_r.mode;
        ADDR_LVL_LO: rd = st_r.lvl[31:0];
        ADDR_LVL_HI: rd = st_r.lvl[63:32];
        ADDR_RUN: rd[NUM_CH-1:0] = st_r.run;
        ADDR_ERR: begin
          rd[ERR_IN_LSB +: NUM_CH] = in_cls;
          rd[ERR_HT_LSB +: NUM_CH] = ht_cls;
          rd[ERR_LINK] = link_hit;
          rd[ERR_ZC_LSB +: NUM_PC] = sy[SY_ZC +: NUM_PC];
          rd[ERR_PCC_LSB +: NUM_PC] = sy[SY_PCC +: NUM_PC];
        end
        ADDR_IRQ_ST: rd[IRQ_W-1:0] = st_r.irq_st;
        ADDR_IRQ_MSK: rd[IRQ_W-1:0] = st_r.irq_msk;
        default: begin
          if (avs_address_i >= ADDR_ALM_BASE &&
              avs_address_i <= ADDR_ALM_LAST) begin
            rd[ALM_INPUT] = in_cls[ai];
            rd[ALM_OC] = sy[SY_OC + int'(ai)];
            rd[ALM_RELAY] = sy[SY_RF + int'(ai)];
            rd[ALM_HB] = sy[SY_HB + int'(ai)];
          end
        end
      endcase
      if (avs_read_i) begin
        st_nxt.rdata = rd;
      end
    end

    // Writes take effect at the edge where waitrequest is seen low.
    if (avs_write_i && !st_r.waitreq) begin
      wm = be_merge(32'h0000_0000, avs_writedata_i, avs_byteenable_i);
      case (avs_address_i)
        ADDR_CMD: begin
          if (wm[CMD_STOP]) begin
            st_nxt.run = '0;
          end
          if (wm[CMD_FCLR]) begin
            // A heater fault latched in this very cycle survives the clear.
            st_nxt.hlatch = '0;
            if (ctrl_tick_i && ph == POL_STOP) begin
              st_nxt.hlatch = ht_raw;
            end
          end
          if (wm[CMD_RUN]) begin
            // Targets still in a stopping fault stay stopped; the fault
            // clear above has already freed latched heater faults.
            if (wm[CMD_FCLR]) begin
              st_nxt.run = st_nxt.run | ~stop_fc;
            end else begin
              st_nxt.run = st_nxt.run | ~stop_req;
            end
          end
          if (wm[CMD_SRST]) begin
            st_nxt.pol_act = st_r.pol_pend;
            st_nxt.run = '0;
            st_nxt.hlatch = '0;
          end
        end
        ADDR_POL_PEND: begin
          if (st_r.run == '0) begin
            mg = be_merge({26'h0, st_r.pol_pend}, avs_writedata_i,
              avs_byteenable_i);
            st_nxt.pol_pend = mg[POL_W-1:0];
          end else begin
            ev[IRQ_REJ] = 1'b1;
          end
        end
        ADDR_MODE: begin
          mg = be_merge({30'h0, st_r.mode}, avs_writedata_i,
            avs_byteenable_i);
          st_nxt.mode = mg[1:0];
        end
        ADDR_LVL_LO: begin
          st_nxt.lvl[31:0] = be_merge(st_r.lvl[31:0],
            avs_writedata_i, avs_byteenable_i);
        end
        ADDR_LVL_HI: begin
          st_nxt.lvl[63:32] = be_merge(st_r.lvl[63:32],
            avs_writedata_i, avs_byteenable_i);
        end
        ADDR_IRQ_ST: begin
          w1c = wm[IRQ_W-1:0];
        end
        ADDR_IRQ_MSK: begin
          mg = be_merge({27'h0, st_r.irq_msk}, avs_writedata_i,
            avs_byteenable_i);
          st_nxt.irq_msk = mg[IRQ_W-1:0];
        end
        default: begin
          st_nxt.mode = st_nxt.mode;
        end
      endcase
    end

    // Sticky events: a new event beats a clear in the same cycle.
    st_nxt.irq_st = (st_r.irq_st & ~w1c) | ev;
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);
  end

  // Register the whole state.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.pol_pend <= POL_RST;
      st_r.pol_act <= POL_RST;
      st_r.mode <= MODE_RST;
      st_r.irq_msk <= MASK_RST;
      st_r.waitreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata_o = st_r.rdata;
  assign avs_waitrequest_o = st_r.waitreq;
  assign mv_o = st_r.mv;
  assign run_o = st_r.run;
  assign irq_o = st_r.irq;

endmodule

// [core/erp_pkg.sv]
// Constants, field layouts and types of the error response policy block.
// Assumes one 100 MHz clock and a 32-bit Avalon-MM register port.
package erp_pkg;

  // Channel layout.
  localparam int NUM_CH = 8;
  localparam int GRP_SIZE = 4;
  localparam int NUM_GRP = 2;
  localparam int PC_CH = 4;
  localparam int NUM_PC = 2;
  localparam int LVL_W = 8;

  // Policy selector codes.
  typedef enum logic [1:0] {
    POL_NOTIFY = 2'h0,
    POL_FORCE = 2'h1,
    POL_STOP = 2'h2
  } erp_pol_t;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_POL_PEND = 8'h04;
  localparam logic [7:0] ADDR_POL_ACT = 8'h08;
  localparam logic [7:0] ADDR_MODE = 8'h0C;
  localparam logic [7:0] ADDR_LVL_LO = 8'h10;
  localparam logic [7:0] ADDR_LVL_HI = 8'h14;
  localparam logic [7:0] ADDR_RUN = 8'h18;
  localparam logic [7:0] ADDR_ERR = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h24;
  localparam logic [7:0] ADDR_ALM_BASE = 8'h40;
  localparam logic [7:0] ADDR_ALM_LAST = 8'h5C;

  // Command bits.
  localparam int CMD_RUN = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_SRST = 2;
  localparam int CMD_FCLR = 3;

  // Selector fields inside the policy registers.
  localparam int POL_LINK_LSB = 0;
  localparam int POL_IN_LSB = 2;
  localparam int POL_HT_LSB = 4;
  localparam int POL_W = 6;

  // Mode bits.
  localparam int MODE_GRAD = 0;
  localparam int MODE_DIRECT = 1;

  // Channel alarm status word bits.
  localparam int ALM_INPUT = 0;
  localparam int ALM_OC = 1;
  localparam int ALM_RELAY = 2;
  localparam int ALM_HB = 11;

  // Error status register fields.
  localparam int ERR_IN_LSB = 0;
  localparam int ERR_HT_LSB = 8;
  localparam int ERR_LINK = 16;
  localparam int ERR_ZC_LSB = 17;
  localparam int ERR_PCC_LSB = 19;

  // Interrupt status and mask bits.
  localparam int IRQ_LINK = 0;
  localparam int IRQ_INPUT = 1;
  localparam int IRQ_HEATER = 2;
  localparam int IRQ_STOP = 3;
  localparam int IRQ_REJ = 4;
  localparam int IRQ_W = 5;

  // Reset values.
  localparam logic [POL_W-1:0] POL_RST = 6'h00;
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

  // Layout of the synchronised fault pin vector.
  localparam int SY_LINK = 0;
  localparam int SY_IN = 1;
  localparam int SY_PCC = 9;
  localparam int SY_ZC = 11;
  localparam int SY_OC = 13;
  localparam int SY_HB = 21;
  localparam int SY_RF = 29;
  localparam int SY_W = 37;

endpackage

// [core/erp_sync3.sv]
// Three-stage synchroniser with agreement filter for fault pins.
// Assumes inputs are asynchronous levels; output is registered.
`timescale 1ns/1ps
module erp_sync3 #(
  parameter int W = 1
) (
  input wire logic mclk_i, // System clock.
  input wire logic resetn_i, // Synchronous reset, active low.
  input wire logic [W-1:0] async_i, // Pin levels.
  output logic [W-1:0] sync_o // Filtered levels.
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } erp_sy_st_t;

  erp_sy_st_t st_r;
  erp_sy_st_t st_nxt;

  // Shift the pins along; a bit changes once stages two and three agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = async_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.out[i] = st_r.s3[i];
      end
    end
  end

  // Register the state.
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.out;

endmodule
